//--- logic/seq_cfg.svh
// Constants for the setpoint list sequencer: register map, fields, depths,
// reset values and dwell timebase.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
`ifndef SEQ_CFG_SVH
`define SEQ_CFG_SVH

// ------------------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------------------
`define ADDR_CONTROL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_REPEAT 8'h08
`define ADDR_FIRST_PASS 8'h0c
`define ADDR_SETPOINT 8'h10
`define ADDR_DWELL 8'h14
`define ADDR_ORDER 8'h18
`define ADDR_READBACK 8'h1c
`define ADDR_RB_COUNT 8'h20
`define ADDR_OUTPUT 8'h24
`define WIN_ORDER 2'h1
`define WIN_SETPOINT 2'h2
`define WIN_DWELL 2'h3

// ------------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------------
`define CTL_RUN 0
`define CTL_USER_ORDER 1
`define CTL_DOWN 2
`define CTL_CLEAR 3
`define STS_RUNNING 0
`define STS_ERROR 1

// ------------------------------------------------------------------------
// Depths, widths and reset values
// ------------------------------------------------------------------------
`define SETPOINT_DEPTH 1002
`define ORDER_DEPTH 512
`define IDX_W 10
`define VAL_W 16
`define WIN_LEN 11'h010
`define RB_CNT_W 5
`define IDX_ZERO 10'h000
`define IDX_ONE 10'h001
`define CNT_ZERO 16'h0000

// ------------------------------------------------------------------------
// Dwell timebase: one tick per millisecond
// ------------------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

//--- logic/seq_pkg.sv
// Types shared by the setpoint list sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package seq_pkg;

  // Execution states, one-hot
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_fetch = 3'b010,
    st_hold = 3'b100
  } run_state_t;

endpackage

`default_nettype wire

//--- logic/dwell_timer.sv
// Dwell timer: counts timebase ticks down from a value loaded per step.
// Assumes load_i is a one-cycle pulse from the sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "seq_cfg.svh"

module dwell_timer #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Step control
  input wire logic load_i,
  input wire logic [`VAL_W-1:0] ticks_i,
  input wire logic abort_i,
  // Expiry
  output logic done_o
);

  logic [15:0] pre_r;
  logic [`VAL_W-1:0] remain_r;
  logic busy_r;
  logic tick;

  // Prescaler restarts at each load so every step gets whole ticks
  assign tick = (pre_r == 16'(TICK_CYCLES - 1));

  // ----------------------------------------------------------------------
  // Tick prescaler
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i || load_i || tick) begin
      pre_r <= 16'h0000;
    end else if (busy_r) begin
      pre_r <= pre_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Remaining ticks and expiry
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i || abort_i) begin
      busy_r <= 1'b0;
      remain_r <= `CNT_ZERO;
      done_o <= 1'b0;
    end else if (load_i) begin
      busy_r <= 1'b1;
      remain_r <= ticks_i;
      done_o <= 1'b0;
    end else begin
      done_o <= busy_r && (remain_r == `CNT_ZERO);
      if (busy_r && remain_r == `CNT_ZERO) begin
        busy_r <= 1'b0;
      end else if (busy_r && tick) begin
        remain_r <= remain_r - 16'h0001;
      end
    end
  end

endmodule // dwell_timer

`default_nettype wire

//--- logic/setpoint_list_sequencer.sv
// Setpoint list sequencer: setpoint, dwell and order tables with an
// execution engine and an Avalon-MM register slave.
// Assumes a 10 MHz clock, synchronous reset and a single bus master.
`timescale 1ns/1ps
`default_nettype none
`include "seq_cfg.svh"

module setpoint_list_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Avalon-MM slave
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Output setpoint
  output logic [`VAL_W-1:0] setpoint_o,
  output logic running_o
);

  // ----------------------------------------------------------------------
  // Storage and settings
  // ----------------------------------------------------------------------
  logic [`VAL_W-1:0] setpoint_table [0:`SETPOINT_DEPTH-1];
  logic [`VAL_W-1:0] dwell_table [0:`SETPOINT_DEPTH-1];
  logic [`IDX_W-1:0] order_table [0:`ORDER_DEPTH-1];
  logic [`IDX_W-1:0] setpoint_fill_pointer_r;
  logic [`IDX_W-1:0] dwell_fill_pointer_r;
  logic [`IDX_W-1:0] order_fill_pointer_r;
  logic [`IDX_W-1:0] readback_pointer_r;
  logic [`VAL_W-1:0] repeat_count_r;
  logic [`VAL_W-1:0] first_pass_only_steps_r;
  logic user_order_r;
  logic down_r;
  logic error_r;
  logic rd_done_r;
  run_state_t state_r;
  logic [`IDX_W-1:0] step_r;
  logic [`VAL_W-1:0] pass_r;
  logic timer_load;
  logic timer_done;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic wr_ctl, wr_sts, wr_rep, wr_fp, wr_sp, wr_dw, wr_ord, wr_rb;
  logic cfg_write, busy, clear_req, run_req, stop_req, start_ok;

  assign busy = (state_r != st_idle);
  assign wr_ctl = write_i && (address_i == `ADDR_CONTROL);
  assign wr_sts = write_i && (address_i == `ADDR_STATUS);
  assign wr_rep = write_i && (address_i == `ADDR_REPEAT);
  assign wr_fp = write_i && (address_i == `ADDR_FIRST_PASS);
  assign wr_sp = write_i && (address_i == `ADDR_SETPOINT);
  assign wr_dw = write_i && (address_i == `ADDR_DWELL);
  assign wr_ord = write_i && (address_i == `ADDR_ORDER);
  assign wr_rb = write_i && (address_i == `ADDR_READBACK);
  assign clear_req = wr_ctl && writedata_i[`CTL_CLEAR];
  assign run_req = wr_ctl && writedata_i[`CTL_RUN] && !busy;
  assign stop_req = wr_ctl && !writedata_i[`CTL_RUN];

  // Any write that changes list settings; the control word counts only
  // when it would alter mode, direction or contents
  assign cfg_write = wr_rep || wr_fp || wr_sp || wr_dw || wr_ord || wr_rb ||
    clear_req ||
    (wr_ctl && (writedata_i[`CTL_USER_ORDER] != user_order_r ||
                writedata_i[`CTL_DOWN] != down_r));

  // ----------------------------------------------------------------------
  // Sequence length and location lookup
  // ----------------------------------------------------------------------
  logic [`IDX_W-1:0] seq_len, pos, loc, skip_idx;
  logic last_step, more_passes;

  assign seq_len = user_order_r ? order_fill_pointer_r
                                : setpoint_fill_pointer_r;
  // Tables must balance and hold something before a run may start; the
  // order bit comes from the start word itself, as the mode flop only
  // takes it on the same edge
  assign start_ok = (setpoint_fill_pointer_r == dwell_fill_pointer_r) &&
    (setpoint_fill_pointer_r != `IDX_ZERO) &&
    (!writedata_i[`CTL_USER_ORDER] ||
     order_fill_pointer_r != `IDX_ZERO);
  // Down walks the same sequence from its far end
  assign pos = down_r ? (seq_len - `IDX_ONE - step_r) : step_r;
  // User order looks up the location; default order uses the position itself
  assign loc = user_order_r ? order_table[pos[8:0]] : pos;
  assign last_step = (step_r + `IDX_ONE >= seq_len);
  // Count zero never runs out of passes
  assign more_passes = (repeat_count_r == `CNT_ZERO) ||
    (pass_r + 16'h0001 < repeat_count_r);
  // A skip count at or beyond the length would leave nothing to run
  assign skip_idx = (first_pass_only_steps_r < {6'h00, seq_len})
    ? first_pass_only_steps_r[`IDX_W-1:0] : `IDX_ZERO;

  // ----------------------------------------------------------------------
  // Execution state machine
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_r <= st_idle;
      step_r <= `IDX_ZERO;
      pass_r <= `CNT_ZERO;
    end else begin
      case (state_r)
        st_idle: begin
          if (run_req && start_ok) begin
            state_r <= st_fetch;
            step_r <= `IDX_ZERO;
            pass_r <= `CNT_ZERO;
          end
        end
        st_fetch: begin
          state_r <= stop_req ? st_idle : st_hold;
        end
        st_hold: begin
          if (stop_req) begin
            state_r <= st_idle;
          end else if (timer_done) begin
            if (!last_step) begin
              step_r <= step_r + `IDX_ONE;
              state_r <= st_fetch;
            end else if (more_passes) begin
              // Wrap straight back, no ramp between passes
              step_r <= skip_idx;
              pass_r <= pass_r + 16'h0001;
              state_r <= st_fetch;
            end else begin
              state_r <= st_idle;
            end
          end
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // Output only moves when a step is fetched, so it holds after a run
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      setpoint_o <= `CNT_ZERO;
    end else if (state_r == st_fetch) begin
      setpoint_o <= setpoint_table[loc];
    end
  end

  assign timer_load = (state_r == st_fetch);
  assign running_o = busy;

  // Dwell for each step, loaded as the step begins
  dwell_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_dwell_timer (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .load_i(timer_load),
    .ticks_i(dwell_table[loc]),
    .abort_i(stop_req),
    .done_o(timer_done)
  );

  // ----------------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------------
  // Settings are frozen while the list runs
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      repeat_count_r <= `CNT_ZERO;
      first_pass_only_steps_r <= `CNT_ZERO;
      user_order_r <= 1'b0;
      down_r <= 1'b0;
    end else if (!busy) begin
      if (wr_rep) begin
        repeat_count_r <= writedata_i[`VAL_W-1:0];
      end
      if (wr_fp) begin
        first_pass_only_steps_r <= writedata_i[`VAL_W-1:0];
      end
      if (wr_ctl) begin
        user_order_r <= writedata_i[`CTL_USER_ORDER];
        down_r <= writedata_i[`CTL_DOWN];
      end
    end
  end

  // Readback pointer: set by host, zeroed by clear
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      readback_pointer_r <= `IDX_ZERO;
    end else if (!busy && clear_req) begin
      readback_pointer_r <= `IDX_ZERO;
    end else if (!busy && wr_rb) begin
      readback_pointer_r <= writedata_i[`IDX_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Table appends and fill pointers
  // ----------------------------------------------------------------------
  logic sp_full, dw_full, ord_full;

  assign sp_full = (setpoint_fill_pointer_r == `IDX_W'(`SETPOINT_DEPTH));
  assign dw_full = (dwell_fill_pointer_r == `IDX_W'(`SETPOINT_DEPTH));
  assign ord_full = (order_fill_pointer_r == `IDX_W'(`ORDER_DEPTH));

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      setpoint_fill_pointer_r <= `IDX_ZERO;
      dwell_fill_pointer_r <= `IDX_ZERO;
      order_fill_pointer_r <= `IDX_ZERO;
    end else if (!busy && clear_req) begin
      setpoint_fill_pointer_r <= `IDX_ZERO;
      dwell_fill_pointer_r <= `IDX_ZERO;
      order_fill_pointer_r <= `IDX_ZERO;
    end else if (!busy) begin
      if (wr_sp && !sp_full) begin
        setpoint_fill_pointer_r <= setpoint_fill_pointer_r + `IDX_ONE;
      end
      if (wr_dw && !dw_full) begin
        dwell_fill_pointer_r <= dwell_fill_pointer_r + `IDX_ONE;
      end
      if (wr_ord && !ord_full) begin
        order_fill_pointer_r <= order_fill_pointer_r + `IDX_ONE;
      end
    end
  end

  // Table contents; stale words past the fill pointers never reach the readback windows
  always_ff @(posedge mclk_i) begin
    if (!busy && !sp_full && wr_sp) begin
      setpoint_table[setpoint_fill_pointer_r] <=
        writedata_i[`VAL_W-1:0];
    end
    if (!busy && !dw_full && wr_dw) begin
      dwell_table[dwell_fill_pointer_r] <= writedata_i[`VAL_W-1:0];
    end
    if (!busy && !ord_full && wr_ord) begin
      order_table[order_fill_pointer_r[8:0]] <=
        writedata_i[`IDX_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Settings error flag
  // ----------------------------------------------------------------------
  // New errors win over a software clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      error_r <= 1'b0;
    end else if ((busy && cfg_write) ||
                 (run_req && !start_ok) ||
                 (!busy && ((wr_sp && sp_full) || (wr_dw && dw_full) ||
                            (wr_ord && ord_full)))) begin
      error_r <= 1'b1;
    end else if (wr_sts && writedata_i[`STS_ERROR]) begin
      error_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Readback windows
  // ----------------------------------------------------------------------
  logic [`IDX_W:0] rb_entry;
  logic [`RB_CNT_W-1:0] cnt_sp, cnt_dw, cnt_ord;

  // Entries left after the pointer, capped at one window
  function automatic logic [`RB_CNT_W-1:0] win_count(
    input logic [`IDX_W-1:0] fill,
    input logic [`IDX_W-1:0] ptr
  );
    logic [`IDX_W:0] left;
    left = {1'b0, fill} - {1'b0, ptr};
    if (ptr >= fill) begin
      win_count = `RB_CNT_W'(0);
    end else if (left > `WIN_LEN) begin
      win_count = `RB_CNT_W'(`WIN_LEN);
    end else begin
      win_count = left[`RB_CNT_W-1:0];
    end
  endfunction

  assign rb_entry = {1'b0, readback_pointer_r} + {7'h00, address_i[5:2]};
  assign cnt_sp = win_count(setpoint_fill_pointer_r, readback_pointer_r);
  assign cnt_dw = win_count(dwell_fill_pointer_r, readback_pointer_r);
  assign cnt_ord = win_count(order_fill_pointer_r, readback_pointer_r);

  // ----------------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [3:0] win_idx;

  assign win_idx = address_i[5:2];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (address_i[7:6])
      `WIN_ORDER: begin
        if ({1'b0, win_idx} < cnt_ord) begin
          rd_mux = {22'h000000, order_table[rb_entry[8:0]]};
        end
      end
      `WIN_SETPOINT: begin
        if ({1'b0, win_idx} < cnt_sp) begin
          rd_mux = {16'h0000,
                    setpoint_table[rb_entry[`IDX_W-1:0]]};
        end
      end
      `WIN_DWELL: begin
        if ({1'b0, win_idx} < cnt_dw) begin
          rd_mux = {16'h0000, dwell_table[rb_entry[`IDX_W-1:0]]};
        end
      end
      default: begin
        case (address_i)
          `ADDR_CONTROL: rd_mux = {28'h0000000, 1'b0, down_r,
                                   user_order_r, busy};
          `ADDR_STATUS: rd_mux = {30'h00000000, error_r, busy};
          `ADDR_REPEAT: rd_mux = {16'h0000, repeat_count_r};
          `ADDR_FIRST_PASS: rd_mux = {16'h0000,
                                      first_pass_only_steps_r};
          `ADDR_SETPOINT: rd_mux = {22'h000000,
                                    setpoint_fill_pointer_r};
          `ADDR_DWELL: rd_mux = {22'h000000, dwell_fill_pointer_r};
          `ADDR_ORDER: rd_mux = {22'h000000, order_fill_pointer_r};
          `ADDR_READBACK: rd_mux = {22'h000000, readback_pointer_r};
          `ADDR_RB_COUNT: rd_mux = {11'h000, cnt_ord, 3'h0, cnt_dw,
                                    3'h0, cnt_sp};
          `ADDR_OUTPUT: rd_mux = {16'h0000, setpoint_o};
          default: rd_mux = 32'h0000_0000;
        endcase
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Avalon read timing: one wait cycle, data from a flop
  // ----------------------------------------------------------------------
  // Registering read data costs a cycle but keeps the table mux off the
  // bus output path
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rd_done_r <= 1'b0;
      readdata_o <= 32'h0000_0000;
    end else if (read_i && !rd_done_r) begin
      rd_done_r <= 1'b1;
      readdata_o <= rd_mux;
    end else begin
      rd_done_r <= 1'b0;
    end
  end

  // Writes complete at once; reads wait for the captured word
  assign waitrequest_o = read_i && !rd_done_r;

endmodule // setpoint_list_sequencer

`default_nettype wire

//--- sim/seq_sva.sv
// Port checker for the setpoint list sequencer.
// Assumes one clock domain and binding onto the top module.
`timescale 1ns/1ps
`default_nettype none
`include "seq_cfg.svh"

// ----------------------------------------
// Checker
// ----------------------------------------
module seq_sva #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Register bus
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  // Output
  input wire logic [`VAL_W-1:0] setpoint_o,
  input wire logic running_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // Control register write decode
  wire logic ctl_wr = write_i && address_i == 8'h00;

  a_reset_clean: assert property ($fell(reset_i) |->
    setpoint_o == '0 && !running_o) else $error("dirty reset state");
  a_run_cause: assert property ($rose(running_o) |->
    $past(ctl_wr && writedata_i[0])) else $error("run without start");
  a_stop_now: assert property (ctl_wr && !writedata_i[0] |=>
    !running_o) else $error("stop late");
  a_idle_hold: assert property (!running_o && !$past(running_o) |->
    $stable(setpoint_o)) else $error("setpoint moved idle");
  a_step_hold: assert property ($changed(setpoint_o) |=>
    $stable(setpoint_o)) else $error("step too short");
  a_wait_once: assert property ($rose(read_i) |->
    waitrequest_o ##1 !waitrequest_o) else $error("read wait wrong");
  a_wait_idle: assert property (!read_i |->
    !waitrequest_o) else $error("wait without read");
  a_rdata_hold: assert property (!read_i && !$past(read_i) |->
    $stable(readdata_o)) else $error("read data moved");
endmodule // seq_sva

bind setpoint_list_sequencer seq_sva #(.TICK_CYCLES(TICK_CYCLES)) seq_sva_inst (
  .mclk_i(mclk_i), .reset_i(reset_i), .address_i(address_i),
  .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
  .setpoint_o(setpoint_o), .running_o(running_o));

`default_nettype wire

//--- sim/host_model.sv
// Host model: Avalon-MM master issuing sequencer setup commands.
// Assumes a single outstanding request; slave may stall with waitrequest.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Host
// ----------------------------------------
module host_model (
  // Clock
  input wire logic mclk_i,
  // Avalon-MM master
  output logic [7:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  input wire logic [31:0] readdata_i,
  input wire logic waitrequest_i
);
  // Idle bus at time zero
  initial begin
    address_o = 8'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0;
  end

  // Write; start, stop and pointer set are writes
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic w;
    address_o <= a;
    writedata_o <= d;
    write_o <= 1'b1;
    // Request stands until an edge sees waitrequest low
    do begin
      @(posedge mclk_i);
      w = waitrequest_i;
    end while (w);
    write_o <= 1'b0;
    // Released lines go inverse so stale values never look valid
    address_o <= ~a;
    writedata_o <= ~d;
    @(posedge mclk_i);
  endtask

  // Read; data taken at the edge where waitrequest is low
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic w;
    address_o <= a;
    read_o <= 1'b1;
    do begin
      @(posedge mclk_i);
      w = waitrequest_i;
      d = readdata_i;
    end while (w);
    read_o <= 1'b0;
    address_o <= ~a;
    @(posedge mclk_i);
  endtask
endmodule // host_model

`default_nettype wire

//--- sim/tb.sv
// Testbench for the setpoint list sequencer.
// Assumes host_model drives the bus; short dwell ticks for speed.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Bench
// ----------------------------------------
module tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] bus_addr;
  logic bus_rd;
  logic bus_wr;
  logic [31:0] bus_wd;
  logic [31:0] bus_rdata;
  logic bus_wait;
  logic [15:0] sp;
  logic running;
  logic [15:0] last_sp = 16'h0;
  logic [15:0] seen_q[$];
  logic [15:0] exp_q[$];
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;

  setpoint_list_sequencer #(.TICK_CYCLES(4)) setpoint_list_sequencer_inst (
    .mclk_i(mclk), .reset_i(reset), .address_i(bus_addr),
    .read_i(bus_rd), .write_i(bus_wr), .writedata_i(bus_wd),
    .readdata_o(bus_rdata), .waitrequest_o(bus_wait),
    .setpoint_o(sp), .running_o(running));

  host_model host_model_inst (
    .mclk_i(mclk), .address_o(bus_addr), .read_o(bus_rd),
    .write_o(bus_wr), .writedata_o(bus_wd), .readdata_i(bus_rdata),
    .waitrequest_i(bus_wait));

  // 10 MHz clock
  always #50 mclk = ~mclk;

  // Record every setpoint change; repeats of a value are invisible here
  always @(posedge mclk) begin
    if (sp !== last_sp) begin
      seen_q.push_back(sp);
      last_sp <= sp;
    end
  end

  // Hang guard, far above the longest run
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out();
    if (err_total == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_model_inst.wr(a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string what);
    logic [31:0] d;
    host_model_inst.rd(a, d);
    chk(what, e, d);
  endtask

  // Start a run, wait for its end, compare the visited values
  task automatic run_chk(input logic [31:0] ctl);
    int n;
    seen_q.delete();
    wr(8'h00, ctl);
    n = 0;
    while (running !== 1'b0 && n < 4000) begin
      @(negedge mclk);
      n++;
    end
    chk("run_end", 32'h0, {31'h0, running});
    chk("steps", exp_q.size(), seen_q.size());
    foreach (exp_q[i]) chk("step", exp_q[i], seen_q[i]);
  endtask

  task automatic s_reset();
    rdc(8'h00, 32'h0, "control");
    rdc(8'h04, 32'h0, "status");
    rdc(8'h10, 32'h0, "sp_fill");
    rdc(8'h28, 32'h0, "unmapped");
    chk("sp", 32'h0, {16'h0, sp});
  endtask

  task automatic s_fill();
    for (int i = 0; i < 5; i++) begin
      wr(8'h10, 32'h100 + i);
      wr(8'h14, 32'h1);
    end
    rdc(8'h10, 32'h5, "sp_fill");
    rdc(8'h14, 32'h5, "dw_fill");
    wr(8'h1c, 32'h2);
    rdc(8'h80, 32'h102, "sp_win0");
    rdc(8'h8c, 32'h0, "sp_win3");
    rdc(8'h20, 32'h303, "win_cnt");
    rdc(8'hc0, 32'h1, "dw_win0");
  endtask

  task automatic s_up();
    wr(8'h08, 32'h2);
    wr(8'h0c, 32'h1);
    rdc(8'h08, 32'h2, "repeat");
    rdc(8'h0c, 32'h1, "first");
    exp_q = '{16'h100, 16'h101, 16'h102, 16'h103, 16'h104,
              16'h101, 16'h102, 16'h103, 16'h104};
    run_chk(32'h1);
    rdc(8'h24, 32'h104, "out");
  endtask

  task automatic s_order();
    wr(8'h1c, 32'h0);
    wr(8'h18, 32'h2);
    wr(8'h18, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h18, 32'h1);
    rdc(8'h18, 32'h4, "ord_fill");
    rdc(8'h4c, 32'h1, "ord_win3");
    wr(8'h10, 32'h105);
    wr(8'h14, 32'h1);
    wr(8'h0c, 32'h0);
    exp_q = '{16'h102, 16'h100, 16'h101, 16'h102, 16'h100, 16'h101};
    run_chk(32'h3);
    rdc(8'h00, 32'h2, "control");
  endtask

  task automatic s_down();
    exp_q = '{16'h105, 16'h104, 16'h103, 16'h102, 16'h101, 16'h100,
              16'h105, 16'h104, 16'h103, 16'h102, 16'h101, 16'h100};
    run_chk(32'h5);
    rdc(8'h00, 32'h4, "control");
  endtask

  task automatic s_refuse();
    wr(8'h10, 32'h106);
    wr(8'h00, 32'h1);
    chk("running", 32'h0, {31'h0, running});
    rdc(8'h04, 32'h2, "status");
    wr(8'h04, 32'h2);
    rdc(8'h04, 32'h0, "status");
  endtask

  task automatic s_forever();
    wr(8'h14, 32'h1);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h1);
    repeat (150) @(negedge mclk);
    chk("running", 32'h1, {31'h0, running});
    wr(8'h08, 32'h3);
    rdc(8'h04, 32'h3, "status");
    rdc(8'h08, 32'h0, "repeat");
    wr(8'h00, 32'h0);
    chk("running", 32'h0, {31'h0, running});
  endtask

  task automatic s_clear();
    wr(8'h1c, 32'h3);
    wr(8'h00, 32'h8);
    rdc(8'h10, 32'h0, "sp_fill");
    rdc(8'h14, 32'h0, "dw_fill");
    rdc(8'h1c, 32'h0, "pointer");
    rdc(8'h80, 32'h0, "sp_win0");
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    s_reset();
    s_fill();
    s_up();
    s_order();
    s_down();
    s_refuse();
    s_forever();
    s_clear();
    close_out();
  end
endmodule // tb

`default_nettype wire
